// ==== hw/bridge_measurement_sequencer.sv ====
// Bridge selection, discharge sequencing and APB register file
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module bridge_measurement_sequencer import bridge_seq_pkg::*; (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic [7:0] o_gauge_out,
	output logic [7:0] o_gauge_oe,
	output logic [1:0] o_charge_out,
	output logic [1:0] o_charge_oe,
	input wire logic [1:0] i_comparator_in,
	output logic o_network_select,
	output logic o_result_flag
);
	// ----------------------------------------
	// Registers and derived settings
	// ----------------------------------------
	cfg_s cfg_reg;
	logic [11:0] avg1_reg, avg2_reg;
	logic [15:0] cycle_reg;
	logic [31:0] prdata_reg;
	logic pready_reg, pslverr_reg;
	seq_state_e st_reg;
	logic [15:0] cnt_reg;
	logic fb_reg, hb_reg, gauge_reg, ind_reg, done_flag_reg, ovf_reg;
	logic pend_valid_reg, pend_fb_reg;
	logic [8:0] t_first_reg;
	logic [9:0] hb0_reg;
	logic [11:0] samp_reg;
	logic [23:0] acc_reg, result_reg;
	logic [1:0] cmp_meta_reg, cmp_sync_reg;
	logic [7:0] gauge_oe_reg;
	logic [1:0] charge_oe_reg;
	logic charge_out_reg, gauge_out_reg, net_sel_reg;
	logic acc_phase, commit, wr, hit, dual, mode2, fullbr, hb_first, hb_last;
	logic cmp_idx, sense, dis_end, last_samp, done_evt, apply, sel_fb, next_fb;
	logic cmd_ok, cmd_fb, wire_active, gain_avail;
	logic [31:0] rd_data;
	logic [11:0] avg_target;
	logic [8:0] tcount;
	logic tsat;
	logic [9:0] hb_now;
	logic [10:0] sample;
	logic [1:0] ps;

	assign ps = cfg_reg.pair_select;
	assign dual = cfg_reg.dual_full_enable;
	assign mode2 = dual && (avg2_reg != 12'h000);
	assign fullbr = dual || ps == PS_SHARED || ps == PS_ALTERNATE;
	assign hb_first = !dual && ps == PS_SECOND;
	assign hb_last = fullbr || ps == PS_SECOND;
	// one comparator behind the Wheatstone mux
	assign cmp_idx = cfg_reg.classic_network_enable ? 1'b0 : ps == PS_SHARED ? 1'b0 :
		dual ? fb_reg : hb_reg;
	assign sense = cmp_sync_reg[cmp_idx];
	// no wire compensation in dual mode
	assign wire_active = cfg_reg.wire_comp && !dual;
	assign gain_avail = cfg_reg.classic_network_enable && cfg_reg.separate_gain_resistor_enable;
	assign avg_target = (mode2 && fb_reg) ? avg2_reg : avg1_reg;

	// ----------------------------------------
	// APB slave, one wait state
	// ----------------------------------------
	assign acc_phase = i_psel && i_penable;
	assign commit = acc_phase && pready_reg;
	assign wr = commit && i_pwrite;

	always_comb begin
		rd_data = 32'h0000_0000;
		hit = 1'b1;
		unique case (i_paddr)
			ADDR_CTRL: rd_data = {21'h0, cfg_reg};
			ADDR_AVG1: rd_data = {20'h0, avg1_reg};
			ADDR_AVG2: rd_data = {20'h0, avg2_reg};
			ADDR_CYCLE: rd_data = {16'h0, cycle_reg};
			ADDR_CMD: rd_data = 32'h0000_0000;
			ADDR_STATUS: rd_data = {ind_reg, 25'h0, mode2, pend_valid_reg, wire_active,
				gain_avail, ovf_reg, done_flag_reg};
			ADDR_RESULT: rd_data = {{8{result_reg[23]}}, result_reg};
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			pready_reg <= acc_phase && !pready_reg;
			if (acc_phase && !pready_reg) begin
				prdata_reg <= i_pwrite ? 32'h0000_0000 : rd_data;
				pslverr_reg <= !hit;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cfg_reg <= cfg_s'(CTRL_RESET);
			avg1_reg <= AVG_RESET;
			avg2_reg <= AVG_RESET;
			cycle_reg <= CYCLE_RESET;
		end else if (wr) begin
			if (i_paddr == ADDR_CTRL) cfg_reg <= cfg_s'(i_pwdata[10:0]);
			if (i_paddr == ADDR_AVG1) avg1_reg <= i_pwdata[11:0];
			if (i_paddr == ADDR_AVG2) avg2_reg <= i_pwdata[11:0];
			if (i_paddr == ADDR_CYCLE) cycle_reg <= i_pwdata[15:0];
		end
	end

	// ----------------------------------------
	// Select commands
	// ----------------------------------------
	// only the two select codes count
	assign cmd_ok = wr && i_paddr == ADDR_CMD && mode2 &&
		(i_pwdata[7:0] == CMD_SEL_FB1 || i_pwdata[7:0] == CMD_SEL_FB2);
	assign cmd_fb = i_pwdata[7:0] == CMD_SEL_FB2;

	// held until the current result ends; same bridge cancels
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pend_valid_reg <= 1'b0;
			pend_fb_reg <= 1'b0;
		end else if (cmd_ok) begin
			pend_valid_reg <= cmd_fb != fb_reg;
			pend_fb_reg <= cmd_fb;
		end else if (apply) begin
			pend_valid_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Comparator synchroniser and timer
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cmp_meta_reg <= 2'b11;
			cmp_sync_reg <= 2'b11;
		end else begin
			cmp_meta_reg <= i_comparator_in;
			cmp_sync_reg <= cmp_meta_reg;
		end
	end

	interval_timer u_timer (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_clear(st_reg == ST_CHARGE),
		.i_run(st_reg == ST_DIS),
		.i_range_two(cfg_reg.range_two),
		.o_count(tcount),
		.o_saturated(tsat)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Non-inverting comparator: low means threshold crossed
	assign dis_end = st_reg == ST_DIS && (!sense || tsat);
	assign hb_now = {1'b0, t_first_reg} - {1'b0, tcount};
	assign sample = !fullbr ? {hb_now[9], hb_now} : cfg_reg.full_difference_enable ?
		{hb_now[9], hb_now} - {hb0_reg[9], hb0_reg} : {hb_now[9], hb_now} + {hb0_reg[9], hb0_reg};
	assign last_samp = dis_end && gauge_reg && hb_reg == hb_last;
	assign done_evt = last_samp && ({1'b0, samp_reg} + 13'h0001 >= {1'b0, avg_target});
	// fixed bridge for codes 1 and 2
	assign sel_fb = ps == PS_FIRST ? 1'b0 : ps == PS_SECOND ? 1'b1 :
		(mode2 && pend_valid_reg) ? pend_fb_reg : fb_reg;
	assign next_fb = !dual ? 1'b0 : (!mode2 && (ps == PS_SHARED || ps == PS_ALTERNATE)) ?
		!fb_reg : sel_fb;
	assign apply = mode2 && (done_evt || (st_reg == ST_IDLE && cfg_reg.run));

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_reg <= ST_IDLE;
			cnt_reg <= 16'h0000;
			hb_reg <= 1'b0;
			gauge_reg <= 1'b0;
			t_first_reg <= 9'h000;
			hb0_reg <= 10'h000;
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
			unique case (st_reg)
				ST_IDLE: begin
					cnt_reg <= 16'h0000;
					hb_reg <= hb_first;
					gauge_reg <= 1'b0;
					if (cfg_reg.run) st_reg <= cfg_reg.precharge_at_start ? ST_PRE : ST_CHARGE;
				end
				ST_PRE: begin
					if (cnt_reg + 16'h0001 >= PRE_CYC +
						(cfg_reg.precharge_start_delay ? PRE_DELAY_CYC : 16'h0000)) begin
						cnt_reg <= 16'h0000;
						st_reg <= ST_CHARGE;
					end
				end
				// charge, then discharge through each gauge
				ST_CHARGE: begin
					if (cnt_reg + 16'h0001 >= CHARGE_CYC) st_reg <= ST_DIS;
				end
				ST_DIS: begin
					cnt_reg <= 16'h0000;
					if (dis_end) begin
						gauge_reg <= !gauge_reg;
						if (!gauge_reg) begin
							t_first_reg <= tcount;
							st_reg <= ST_CHARGE;
						end else if (hb_reg != hb_last) begin
							hb0_reg <= hb_now;
							hb_reg <= 1'b1;
							st_reg <= ST_CHARGE;
						end else begin
							hb_reg <= hb_first;
							st_reg <= ST_WAIT;
						end
					end
				end
				// one cycle time for both bridges
				ST_WAIT: begin
					if (cnt_reg + 16'h0001 >= cycle_reg) begin
						cnt_reg <= 16'h0000;
						st_reg <= !cfg_reg.run ? ST_IDLE :
							(samp_reg == 12'h000 && cfg_reg.precharge_at_start) ? ST_PRE : ST_CHARGE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			samp_reg <= 12'h000;
			acc_reg <= 24'h00_0000;
			result_reg <= 24'h00_0000;
			ind_reg <= 1'b0;
			fb_reg <= 1'b0;
		end else if (st_reg == ST_IDLE) begin
			samp_reg <= 12'h000;
			acc_reg <= 24'h00_0000;
			fb_reg <= dual ? sel_fb : 1'b0;
		end else if (done_evt) begin
			samp_reg <= 12'h000;
			acc_reg <= 24'h00_0000;
			result_reg <= acc_reg + {{13{sample[10]}}, sample};
			// low for bridge 1, high for bridge 2
			ind_reg <= fb_reg;
			fb_reg <= next_fb;
		end else if (last_samp) begin
			samp_reg <= samp_reg + 12'h001;
			acc_reg <= acc_reg + {{13{sample[10]}}, sample};
		end
	end

	// result flag, set beats software clear
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			done_flag_reg <= 1'b0;
			ovf_reg <= 1'b0;
		end else begin
			done_flag_reg <= done_evt ||
				(done_flag_reg && !(wr && i_paddr == ADDR_STATUS && i_pwdata[ST_DONE_BIT]));
			ovf_reg <= (dis_end && tsat) ||
				(ovf_reg && !(wr && i_paddr == ADDR_STATUS && i_pwdata[1]));
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pin
			always_ff @(posedge i_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					gauge_oe_reg[gi] <= 1'b0;
				end else begin
					gauge_oe_reg[gi] <= (dual ? fb_reg == gi / 4 : 1'b1) &&
						(gi % 4) / 2 == int'(hb_reg) &&
						((st_reg == ST_DIS && gi % 2 == int'(gauge_reg)) || st_reg == ST_CHARGE);
				end
			end
		end
	endgenerate

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			gauge_out_reg <= 1'b0;
			charge_out_reg <= 1'b0;
			charge_oe_reg <= 2'b00;
			net_sel_reg <= 1'b0;
		end else begin
			gauge_out_reg <= st_reg == ST_CHARGE;
			charge_out_reg <= st_reg == ST_CHARGE || st_reg == ST_PRE;
			charge_oe_reg[0] <= (st_reg == ST_CHARGE || st_reg == ST_PRE) && !cmp_idx;
			charge_oe_reg[1] <= (st_reg == ST_CHARGE || st_reg == ST_PRE) && cmp_idx;
			net_sel_reg <= cfg_reg.classic_network_enable && hb_reg;
		end
	end

	assign o_prdata = prdata_reg;
	assign o_pready = pready_reg;
	assign o_pslverr = pslverr_reg;
	assign o_gauge_oe = gauge_oe_reg;
	assign o_gauge_out = {8{gauge_out_reg}};
	assign o_charge_out = {2{charge_out_reg}};
	assign o_charge_oe = charge_oe_reg;
	assign o_network_select = net_sel_reg;
	assign o_result_flag = done_flag_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	property p_flag_set;
		done_evt |=> done_flag_reg && o_result_flag;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set");

	property p_indicator;
		done_evt |=> ind_reg == $past(fb_reg);
	endproperty
	a_indicator: assert property (p_indicator) else $error("bad bridge bit");

	property p_alternate;
		done_evt && dual && !mode2 && (ps == PS_SHARED || ps == PS_ALTERNATE)
			|=> fb_reg != $past(fb_reg);
	endproperty
	a_alternate: assert property (p_alternate) else $error("no alternation");

	property p_fb_hold;
		st_reg != ST_IDLE && !done_evt |=> $stable(fb_reg);
	endproperty
	a_fb_hold: assert property (p_fb_hold) else $error("bridge changed early");

	property p_paired;
		!dual && $past(!dual) |-> gauge_oe_reg[3:0] == gauge_oe_reg[7:4];
	endproperty
	a_paired: assert property (p_paired) else $error("pins not paired");

	property p_separate;
		dual && $past(dual, 2) |-> !(|gauge_oe_reg[3:0] && |gauge_oe_reg[7:4]);
	endproperty
	a_separate: assert property (p_separate) else $error("both sets driven");

	property p_no_wire;
		dual |-> !wire_active;
	endproperty
	a_no_wire: assert property (p_no_wire) else $error("wire comp in dual");

	property p_range;
		tcount <= TIMER_MAX;
	endproperty
	a_range: assert property (p_range) else $error("interval over range");

	property p_half_sel;
		st_reg == ST_DIS && !dual && (ps == PS_FIRST || ps == PS_SECOND)
			|-> hb_reg == (ps == PS_SECOND);
	endproperty
	a_half_sel: assert property (p_half_sel) else $error("wrong half-bridge");

	property p_discharge;
		st_reg == ST_DIS && $past(st_reg) == ST_DIS |-> charge_oe_reg == 2'b00 &&
			$countones(gauge_oe_reg) inside {1, 2};
	endproperty
	a_discharge: assert property (p_discharge) else $error("bad discharge drive");

	property p_cmd;
		cmd_ok && cmd_fb != fb_reg && !done_evt |=> pend_valid_reg && pend_fb_reg == $past(cmd_fb);
	endproperty
	a_cmd: assert property (p_cmd) else $error("select lost");
endmodule // bridge_measurement_sequencer

// ==== shared/bridge_seq_pkg.sv ====
// Constants, layouts and types of the bridge measurement sequencer
// Function
// - Charge capacitor, then discharge it through each gauge of the selected pair.
// - Pair select 1 measures ports A/B, 2 measures ports C/D.
// - Pair select 0 is one-comparator full-bridge, 3 is interleaved two-comparator.
// - Difference bit subtracts half-bridges, A/B half taken as inverted.
// - Dual enable 0 means one full-bridge, 1 means two full-bridges.
// - In dual mode pair select picks shared, first, second or alternating bridges.
// - Dual mode drives every gauge pin alone, no paired drive.
// - Second averaging count zero gives automatic alternation, nonzero gives commanded bridge.
// - Auto mode with pair select 0 or 3 alternates bridges, flags each result, starts the other one.
// - Status top bit tells which full-bridge made the last result.
// - Command 0x08 selects full-bridge 1, 0x09 selects full-bridge 2.
// - Commanded mode averages bridge 1 by first count, bridge 2 by second.
// - Select during a measurement acts after its flag, then sticks.
// - Both bridges share one cycle time in commanded mode.
// - Classic network enable runs Wheatstone operation, combinable with dual mode.
// - Wire resistance compensation is withheld during dual full-bridge operation.
// - Range 2 counts with the reference predivider, up to 2^8 periods.
package bridge_seq_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int CHARGE_NS = 2000;
	localparam int PRE_NS = 5000;
	localparam int PRE_DELAY_NS = 10000;
	localparam logic [15:0] CHARGE_CYC = 16'((CHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] PRE_CYC = 16'((PRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] PRE_DELAY_CYC =
		16'((PRE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// Reference clock as a divided enable, range limit 2^8 periods
	localparam logic [3:0] REF_DIV = 4'h4;
	localparam logic [8:0] TIMER_MAX = 9'h100;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_AVG1 = 8'h04;
	localparam logic [7:0] ADDR_AVG2 = 8'h08;
	localparam logic [7:0] ADDR_CYCLE = 8'h0c;
	localparam logic [7:0] ADDR_CMD = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_RESULT = 8'h18;
	localparam logic [10:0] CTRL_RESET = 11'h000;
	localparam logic [11:0] AVG_RESET = 12'h000;
	localparam logic [15:0] CYCLE_RESET = 16'h0010;
	localparam int ST_DONE_BIT = 0;
	localparam int ST_IND_BIT = 31;
	localparam logic [7:0] CMD_SEL_FB1 = 8'h08;
	localparam logic [7:0] CMD_SEL_FB2 = 8'h09;

	// ----------------------------------------
	// Pair select codes
	// ----------------------------------------
	localparam logic [1:0] PS_SHARED = 2'h0;
	localparam logic [1:0] PS_FIRST = 2'h1;
	localparam logic [1:0] PS_SECOND = 2'h2;
	localparam logic [1:0] PS_ALTERNATE = 2'h3;

	// Control register, bit 0 at the bottom
	typedef struct packed {
		logic range_two;
		logic wire_comp;
		logic precharge_start_delay;
		logic precharge_at_start;
		logic separate_gain_resistor_enable;
		logic classic_network_enable;
		logic dual_full_enable;
		logic full_difference_enable;
		logic [1:0] pair_select;
		logic run;
	} cfg_s;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PRE,
		ST_CHARGE,
		ST_DIS,
		ST_WAIT
	} seq_state_e;
endpackage

// ==== hw/interval_timer.sv ====
// Discharge interval counter with reference predivider
`timescale 1ns/100ps
module interval_timer import bridge_seq_pkg::*; (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_clear,
	input wire logic i_run,
	input wire logic i_range_two,
	output logic [8:0] o_count,
	output logic o_saturated
);
	logic [3:0] div_reg;
	logic tick;

	assign tick = i_range_two ? (div_reg == REF_DIV - 4'h1) : 1'b1;
	assign o_saturated = (o_count == TIMER_MAX);

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			div_reg <= 4'h0;
		end else if (i_clear || tick) begin
			div_reg <= 4'h0;
		end else if (i_run) begin
			div_reg <= div_reg + 4'h1;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_count <= 9'h000;
		end else if (i_clear) begin
			o_count <= 9'h000;
		end else if (i_run && tick && !o_saturated) begin
			o_count <= o_count + 9'h001;
		end
	end
endmodule // interval_timer

// ==== verif/bridge_gauge_model.sv ====
// Behavioural gauges, discharge capacitor and comparator at the gauge pins
`timescale 1ns/100ps
module bridge_gauge_model #(
	parameter logic [7:0][7:0] TAU = {8'h19, 8'h2d, 8'h23, 8'h3c, 8'h14, 8'h32, 8'h1e, 8'h28}
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [7:0] i_gauge_out,
	input wire logic [7:0] i_gauge_oe,
	input wire logic [1:0] i_charge_out,
	input wire logic [1:0] i_charge_oe,
	output logic [1:0] o_comparator_in
);
	logic [7:0] draining;
	int elapsed;
	int limit;

	assign draining = i_gauge_oe & ~i_gauge_out;

	// One shared capacitor seen by both comparators, so one-sense and
	// two-comparator wiring cross the threshold at the same time
	always_comb begin
		limit = 0;
		for (int k = 7; k >= 0; k--) begin
			if (draining[k])
				limit = int'(TAU[k]);
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			elapsed <= 0;
			o_comparator_in <= 2'h3;
		end else if ((i_charge_oe & i_charge_out) != 2'h0) begin
			elapsed <= 0;
			o_comparator_in <= 2'h3;
		end else if (draining != 8'h00) begin
			elapsed <= elapsed + 1;
			if (elapsed + 1 >= limit)
				o_comparator_in <= 2'h0;
		end
	end
endmodule // bridge_gauge_model

// ==== verif/tb.sv ====
// Self-checking testbench of the bridge measurement sequencer
`timescale 1ns/100ps
module tb import bridge_seq_pkg::*; ;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] gauge_out;
	logic [7:0] gauge_oe;
	logic [1:0] charge_out;
	logic [1:0] charge_oe;
	logic [1:0] comp_in;
	logic network_select;
	logic result_flag;
	int miscompares = 0;
	int samples_checked = 0;
	int cyc = 0;
	int stamp = 0;
	int last = 0;
	int t1 = 0;
	logic dual_watch = 1'b0;
	logic multi_drive = 1'b0;
	logic net_seen = 1'b0;
	logic prev;
	logic err;
	logic [31:0] rv;
	logic [31:0] st;
	logic [31:0] res;
	logic [7:0] ra [5] = '{ADDR_CTRL, ADDR_AVG1, ADDR_AVG2, ADDR_CYCLE, ADDR_STATUS};
	logic [31:0] re [5] = '{32'h0, 32'h0, 32'h0, {16'h0, CYCLE_RESET}, 32'h0};
	logic [31:0] cfg [6] = '{32'h2, 32'h4, 32'h0, 32'h6, 32'he, 32'h1e6};
	logic [31:0] exp_res [6] = '{32'ha, 32'h1e, 32'h28, 32'h28, 32'h14, 32'h28};
	logic [31:0] sc [4] = '{32'h200, 32'h210, 32'h60, 32'h20};
	int sb [4] = '{3, 3, 2, 2};

	always #50 clk = ~clk;

	// Dual mode must never drain through two pins at once
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (dual_watch && $countones(gauge_oe & ~gauge_out) > 1)
			multi_drive <= 1'b1;
		if (network_select)
			net_seen <= 1'b1;
	end

	bridge_measurement_sequencer bridge_measurement_sequencer_i (
		.i_clk(clk), .i_reset_n(reset_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .o_gauge_out(gauge_out),
		.o_gauge_oe(gauge_oe), .o_charge_out(charge_out), .o_charge_oe(charge_oe),
		.i_comparator_in(comp_in), .o_network_select(network_select),
		.o_result_flag(result_flag)
	);

	bridge_gauge_model bridge_gauge_model_i (
		.i_clk(clk), .i_reset_n(reset_n), .i_gauge_out(gauge_out), .i_gauge_oe(gauge_oe),
		.i_charge_out(charge_out), .i_charge_oe(charge_oe), .o_comparator_in(comp_in)
	);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			check(32'h0, 32'h1, "pready");
	endtask

	task automatic wait_flag();
		int n;
		n = 0;
		while (result_flag !== 1'b1 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 4000)
			check(32'h0, 32'h1, "flag wait");
		stamp = cyc;
		apb(1'b0, ADDR_STATUS, 32'h0);
		st = rv;
		apb(1'b0, ADDR_RESULT, 32'h0);
		res = rv;
		apb(1'b1, ADDR_STATUS, 32'h1);
		repeat (2) @(posedge clk);
	endtask

	// Stop, let a running sample finish, clear flags, load idle config
	// Pin watch only while the dual setting is loaded; a stopping run still pairs pins
	task automatic start(input logic [31:0] ctrl);
		dual_watch = 1'b0;
		apb(1'b1, ADDR_CTRL, 32'h0);
		repeat (500) @(posedge clk);
		apb(1'b1, ADDR_STATUS, 32'h3);
		apb(1'b1, ADDR_CTRL, ctrl);
		dual_watch = ctrl[4];
	endtask

	task automatic tally_and_finish();
		$display("Checked %0d values, %0d mismatches", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		tally_and_finish();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, ra[i], 32'h0);
			check(rv, re[i], "reset value");
		end
		apb(1'b1, 8'h1c, 32'h5);
		check({31'h0, err}, 32'h1, "unmapped error");
		apb(1'b0, 8'h1c, 32'h0);
		check(rv, 32'h0, "unmapped data");
		apb(1'b1, ADDR_RESULT, 32'h55);
		apb(1'b0, ADDR_RESULT, 32'h0);
		check(rv, 32'h0, "result read only");
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, ADDR_CTRL, sc[i]);
			apb(1'b0, ADDR_STATUS, 32'h0);
			check({31'h0, rv[sb[i]]}, {31'h0, ~i[0]}, "status option");
		end
		// Half, full, difference and classic network runs
		for (int i = 0; i < 6; i++) begin
			start(cfg[i]);
			apb(1'b1, ADDR_CTRL, cfg[i] | 32'h1);
			wait_flag();
			check(res, exp_res[i], "single result");
			check({31'h0, st[ST_IND_BIT]}, 32'h0, "single indicator");
		end
		check({31'h0, net_seen}, 32'h1, "network select");
		start(32'h402);
		apb(1'b1, ADDR_CTRL, 32'h403);
		wait_flag();
		check({31'h0, res inside {32'h1, 32'h2, 32'h3}}, 32'h1, "range two");
		// Dual bridges, automatic alternation
		start(32'h1e);
		apb(1'b0, ADDR_STATUS, 32'h0);
		check({31'h0, rv[5]}, 32'h0, "mode one");
		apb(1'b1, ADDR_CTRL, 32'h1f);
		for (int i = 0; i < 3; i++) begin
			prev = st[ST_IND_BIT];
			wait_flag();
			check(res, st[ST_IND_BIT] ? 32'hfffffffb : 32'h14, "dual result");
			if (i > 0)
				check({31'h0, st[ST_IND_BIT]}, {31'h0, ~prev}, "alternation");
			t1 = stamp - last;
			last = stamp;
		end
		// Dual bridges, commanded selection
		start(32'h1e);
		apb(1'b1, ADDR_AVG2, 32'h2);
		apb(1'b0, ADDR_STATUS, 32'h0);
		check({31'h0, rv[5]}, 32'h1, "mode two");
		apb(1'b1, ADDR_CMD, {24'h0, CMD_SEL_FB1});
		apb(1'b1, ADDR_CTRL, 32'h1f);
		apb(1'b1, ADDR_CMD, {24'h0, CMD_SEL_FB2});
		apb(1'b0, ADDR_STATUS, 32'h0);
		check({31'h0, rv[4]}, 32'h1, "select pending");
		wait_flag();
		check(res, 32'h14, "first bridge result");
		check({31'h0, st[ST_IND_BIT]}, 32'h0, "first indicator");
		wait_flag();
		last = stamp;
		check({31'h0, st[ST_IND_BIT]}, 32'h1, "switched indicator");
		wait_flag();
		check({31'h0, st[ST_IND_BIT]}, 32'h1, "kept indicator");
		check({31'h0, (stamp - last) * 2 > t1 * 3}, 32'h1, "second count span");
		apb(1'b1, ADDR_CMD, {24'h0, CMD_SEL_FB2});
		apb(1'b0, ADDR_STATUS, 32'h0);
		check({31'h0, rv[4]}, 32'h0, "same select");
		check({31'h0, multi_drive}, 32'h0, "single pin drive");
		tally_and_finish();
	end
endmodule // tb
